/* rtl/gicac_defines.svh */
// Constants for the guest indirect register access control block
`ifndef GICAC_DEFINES_SVH
`define GICAC_DEFINES_SVH

// ----------------------------------------------------------------
// APB byte offsets
// ----------------------------------------------------------------
`define GICAC_OFS_CFG 8'h00
`define GICAC_OFS_REQ 8'h04
`define GICAC_OFS_WLO 8'h08
`define GICAC_OFS_WHI 8'h0C
`define GICAC_OFS_RES 8'h10
`define GICAC_OFS_RLO 8'h14
`define GICAC_OFS_RHI 8'h18
`define GICAC_OFS_HSL 8'h1C
`define GICAC_OFS_VSL 8'h20

// ----------------------------------------------------------------
// Register numbers and alias slots
// ----------------------------------------------------------------
`define GICAC_CSR_SSEL  12'h150
`define GICAC_CSR_GSEL  12'h250
`define GICAC_ALIAS_GAP 4'h4
`define GICAC_ALIAS_MAX 4'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GICAC_CFG_RST 7'h7C
`define GICAC_HSL_RST 12'h010
`define GICAC_VSL_RST 12'h008

`endif

/* rtl/gicac_pkg.sv */
// Types shared by the guest indirect register access control block
package gicac_pkg;

	typedef enum logic [1:0] {MODE_M, MODE_HS, MODE_VS, MODE_VU} gicac_mode_t;
	typedef enum logic [1:0] {EXC_NONE, EXC_ILLEGAL, EXC_VIRTUAL} gicac_exc_t;
	typedef enum logic {ST_IDLE, ST_EXEC} gicac_st_t;

	// Control word, most significant field first
	typedef struct packed {
		logic        xgate;
		logic        hgate;
		logic        mgate;
		logic        sen;
		logic        wide;
		gicac_mode_t mode;
	} gicac_cfg_t;

	typedef struct packed {
		logic        wr;
		logic [11:0] csr;
	} gicac_req_t;

	typedef struct packed {
		logic       redir;
		logic       done;
		gicac_exc_t exc;
	} gicac_res_t;

endpackage : gicac_pkg

/* rtl/gicac_top.sv */
// Guest indirect register select and alias access control with APB slave
`timescale 1ns/100ps
`default_nettype none
`include "gicac_defines.svh"

module gicac_top
	import gicac_pkg::*;
#(
	parameter int XLEN         = 64,
	parameter int SEL_W        = 12,
	parameter int DEPTH        = 16,
	parameter bit MACHINE_VIEW = 1'b1
)(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             acc_done,
	output gicac_exc_t       acc_exc
);

	localparam int IW = $clog2(DEPTH);
	localparam int MW = 2 * DEPTH * 8;
	localparam logic [SEL_W-1:0] DEPTH_V = SEL_W'(DEPTH);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	gicac_cfg_t        cfg_q;
	gicac_req_t        req_q;
	gicac_res_t        res_q;
	gicac_st_t         state_q;
	logic [XLEN-1:0]   wdat_q;
	logic [XLEN-1:0]   rdat_q;
	logic [SEL_W-1:0]  hsl_q;
	logic [SEL_W-1:0]  vsl_q;
	logic [SEL_W-1:0]  gsel_q;
	logic [SEL_W-1:0]  ssel_q;
	logic              gcus_q;
	logic              scus_q;
	logic [XLEN-1:0]   mem [0:MW-1];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic        apb_acc;
	logic        apb_fin;
	logic        wr_en;
	logic        hit;
	logic [31:0] rd_mux;

	// Answer comes one cycle into the access phase
	assign apb_acc = psel & penable & ~pready;
	assign apb_fin = psel & penable & pready;
	assign wr_en   = apb_fin & pwrite;

	// Read data and address decode
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		hit    = 1'b1;
		case (paddr)
			`GICAC_OFS_CFG: rd_mux = 32'(cfg_q);
			`GICAC_OFS_REQ: rd_mux = 32'(req_q);
			`GICAC_OFS_WLO: rd_mux = wdat_q[31:0];
			`GICAC_OFS_WHI: rd_mux = wdat_q[XLEN-1:32];
			`GICAC_OFS_RES: rd_mux = 32'(res_q);
			`GICAC_OFS_RLO: rd_mux = rdat_q[31:0];
			`GICAC_OFS_RHI: rd_mux = rdat_q[XLEN-1:32];
			`GICAC_OFS_HSL: rd_mux = 32'(hsl_q);
			`GICAC_OFS_VSL: rd_mux = 32'(vsl_q);
			default:        hit    = 1'b0;
		endcase
	end

	// Bus answer flops
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready  <= apb_acc;
			pslverr <= apb_acc & ~hit;
			prdata  <= apb_acc ? rd_mux : 32'h0000_0000;
		end
	end

	// Software-written configuration and request fields
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_q  <= gicac_cfg_t'(`GICAC_CFG_RST);
			req_q  <= '0;
			wdat_q <= '0;
			hsl_q  <= SEL_W'(`GICAC_HSL_RST);
			vsl_q  <= SEL_W'(`GICAC_VSL_RST);
		end
		else if (ce && wr_en)
		begin
			case (paddr)
				`GICAC_OFS_CFG: cfg_q <= gicac_cfg_t'(pwdata[$bits(gicac_cfg_t)-1:0]);
				`GICAC_OFS_REQ: req_q <= gicac_req_t'(pwdata[$bits(gicac_req_t)-1:0]);
				`GICAC_OFS_WLO: wdat_q[31:0] <= pwdata;
				`GICAC_OFS_WHI: wdat_q[XLEN-1:32] <= pwdata[XLEN-33:0];
				`GICAC_OFS_HSL: hsl_q <= pwdata[SEL_W-1:0];
				`GICAC_OFS_VSL: vsl_q <= pwdata[SEL_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic [3:0]       lo;
	logic             s_hit;
	logic             g_hit;
	logic             is_sel;
	logic             is_ali;
	logic             virt;
	logic             below_m;
	logic             mg_ok;
	logic             tgt_g;
	logic [SEL_W-1:0] sel_v;
	logic             cus_v;
	logic             hs_impl;
	logic             vs_impl;
	logic [IW+3:0]    idx;

	// Only the two register groups are decoded; the guest group always exists
	assign lo      = req_q.csr[3:0];
	assign s_hit   = req_q.csr[11:4] == 8'(`GICAC_CSR_SSEL >> 4);
	assign g_hit   = req_q.csr[11:4] == 8'(`GICAC_CSR_GSEL >> 4);
	assign is_sel  = lo == 4'h0;
	assign is_ali  = lo != 4'h0 && lo != `GICAC_ALIAS_GAP && lo <= `GICAC_ALIAS_MAX;
	assign virt    = cfg_q.mode == MODE_VS || cfg_q.mode == MODE_VU;
	assign below_m = cfg_q.mode != MODE_M;
	// Supervisor-only build has no machine gate to consult
	assign mg_ok   = !MACHINE_VIEW || !cfg_q.sen || cfg_q.mgate;
	// Guest mode always lands on the guest copy
	assign tgt_g   = g_hit | virt;
	assign sel_v   = tgt_g ? gsel_q : ssel_q;
	assign cus_v   = tgt_g ? gcus_q : scus_q;
	// Custom values are not implemented here
	assign hs_impl = !cus_v && sel_v < hsl_q && sel_v < DEPTH_V;
	assign vs_impl = hs_impl && sel_v < vsl_q;
	assign idx     = {tgt_g, sel_v[IW-1:0], lo[2:0]};

	gicac_exc_t d_exc;
	logic       d_acc;

	// Register decode first, then mode gates, then select range, then the xgate gate; a gated access touches nothing;
	// the hs_impl test is applied to these aliases, and vs_impl from guest modes
	always_comb
	begin
		d_exc = EXC_NONE;
		d_acc = 1'b0;
		if (!(s_hit || g_hit) || !(is_sel || is_ali))
			d_exc = EXC_ILLEGAL;
		else if (below_m && !mg_ok)
			d_exc = EXC_ILLEGAL;
		else if (virt && g_hit)
			d_exc = EXC_VIRTUAL;
		else if (cfg_q.mode == MODE_VU)
			d_exc = EXC_VIRTUAL;
		else if (virt && cfg_q.sen && !cfg_q.hgate)
			d_exc = EXC_VIRTUAL;
		else if (is_ali && !hs_impl)
			d_exc = EXC_ILLEGAL;
		else if (is_ali && virt && !vs_impl)
			d_exc = EXC_VIRTUAL;
		else if (is_ali && below_m && cfg_q.sen && !cfg_q.xgate)
			d_exc = EXC_ILLEGAL;
		else
			d_acc = 1'b1;
	end

	// Select as read at the current width; custom bit sits on top
	logic [XLEN-1:0] sel_rd;
	logic [XLEN-1:0] wr_val;

	always_comb
	begin
		sel_rd = XLEN'(sel_v);
		if (cfg_q.wide)
			sel_rd[XLEN-1] = cus_v;
		else
			sel_rd[31] = cus_v;
		wr_val = cfg_q.wide ? wdat_q : {{(XLEN-32){1'b0}}, wdat_q[31:0]};
	end

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	logic exec;
	logic start;

	assign exec  = state_q == ST_EXEC;
	assign start = wr_en && paddr == `GICAC_OFS_REQ;

	// One evaluation cycle per request
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			state_q <= ST_IDLE;
		else if (ce)
		begin
			unique case (state_q)
				ST_IDLE: state_q <= start ? ST_EXEC : ST_IDLE;
				ST_EXEC: state_q <= ST_IDLE;
			endcase
		end
	end

	// Outcome and read data; done clears on a new request, set is later
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			res_q    <= '0;
			rdat_q   <= '0;
			acc_done <= 1'b0;
			acc_exc  <= EXC_NONE;
		end
		else if (ce)
		begin
			acc_done <= exec;
			if (exec)
			begin
				res_q    <= '{redir: virt && s_hit, done: 1'b1, exc: d_exc};
				acc_exc  <= d_exc;
				rdat_q   <= '0;
				if (d_acc && !req_q.wr)
				begin
					if (is_sel)
						rdat_q <= sel_rd;
					else
						rdat_q <= cfg_q.wide ? mem[idx] : XLEN'(mem[idx][31:0]);
				end
			end
			else if (start)
				res_q.done <= 1'b0;
		end
	end

	// Both selects share one width and hold 0..0xFFF at least
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			gsel_q <= '0;
			ssel_q <= '0;
			gcus_q <= 1'b0;
			scus_q <= 1'b0;
		end
		else if (ce && exec && d_acc && req_q.wr && is_sel)
		begin
			if (tgt_g)
			begin
				gsel_q <= wdat_q[SEL_W-1:0];
				gcus_q <= cfg_q.wide ? wdat_q[XLEN-1] : wdat_q[31];
			end
			else
			begin
				ssel_q <= wdat_q[SEL_W-1:0];
				scus_q <= cfg_q.wide ? wdat_q[XLEN-1] : wdat_q[31];
			end
		end
	end

	// Indirect state; no reset, software initialises it
	always_ff @(posedge clock)
	begin
		if (ce && exec && d_acc && req_q.wr && is_ali)
			mem[idx] <= wr_val;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	logic valid_r;

	assign valid_r = (s_hit || g_hit) && (is_sel || is_ali);

	sequence s_setup;
		psel && !penable && ce;
	endsequence

	sequence s_access;
		psel && penable && !pready && ce;
	endsequence

	sequence s_req_write;
		ce && start;
	endsequence

	AST_APB_ANSWER: assert property (s_setup ##1 s_access |=> pready)
		else $error("APB answer not one cycle into access");

	// A low clock enable only stretches the evaluation cycle, so check per step
	AST_REQ_EVAL: assert property (s_req_write |=> exec)
		else $error("request not evaluated");

	AST_EXEC_DONE: assert property (ce && exec |=> acc_done)
		else $error("evaluation did not report done");

	AST_MGATE_ILLEGAL: assert property (
		ce && exec && valid_r && below_m && !mg_ok |=> acc_exc == EXC_ILLEGAL)
		else $error("machine gate did not raise illegal");

	AST_M_UNGATED: assert property (
		ce && exec && valid_r && is_sel && cfg_q.mode == MODE_M |=> acc_exc == EXC_NONE)
		else $error("M-mode select access was restricted");

	AST_GUEST_DIRECT: assert property (
		ce && exec && valid_r && virt && g_hit && mg_ok |=> acc_exc == EXC_VIRTUAL)
		else $error("guest direct access not virtual fault");

	AST_HGATE_VIRT: assert property (
		ce && exec && valid_r && s_hit && cfg_q.mode == MODE_VS && mg_ok
		&& cfg_q.sen && !cfg_q.hgate |=> acc_exc == EXC_VIRTUAL && res_q.done)
		else $error("hyper gate did not raise virtual fault");

	AST_REDIRECT: assert property (
		ce && exec && d_exc == EXC_NONE && cfg_q.mode == MODE_VS && s_hit && is_sel
		&& req_q.wr |=> gsel_q == $past(wdat_q[SEL_W-1:0]) && $stable(ssel_q))
		else $error("guest supervisor select not redirected");

	AST_HS_UNIMPL: assert property (
		ce && exec && cfg_q.mode == MODE_M && g_hit && is_ali && !hs_impl
		|=> acc_exc == EXC_ILLEGAL)
		else $error("unimplemented select did not fault");

	AST_VS_ONLY: assert property (
		ce && exec && cfg_q.mode == MODE_VS && s_hit && is_ali && hs_impl && !vs_impl
		&& mg_ok && (!cfg_q.sen || cfg_q.hgate) |=> acc_exc == EXC_VIRTUAL)
		else $error("HS-only select from VS not virtual fault");

	AST_NARROW: assert property (
		ce && exec && !cfg_q.wide |=> rdat_q[XLEN-1:32] == '0)
		else $error("narrow access returned upper bits");

	AST_GATED_NO_TOUCH: assert property (
		ce && exec && d_exc != EXC_NONE |=> $stable(gsel_q) && $stable(ssel_q)
		&& rdat_q == '0)
		else $error("faulting access touched state");

endmodule : gicac_top
`default_nettype wire

/* bench/gicac_tb.sv */
// Self-checking bench for the guest indirect register access control block
`timescale 1ns/100ps
`default_nettype none
`include "gicac_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module testbench
	import gicac_pkg::*;
;
	logic        clock, resetn, ce, psel, penable, pwrite, pready, pslverr, acc_done, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, rlo, rhi;
	gicac_exc_t  acc_exc;
	int          fail_count, checks_done, cyc;

	// ------------------------------------------------------------
	// Design, clock and hang guard
	// ------------------------------------------------------------
	gicac_top i_dut (
		.clock    (clock),
		.resetn   (resetn),
		.ce       (ce),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.acc_done (acc_done),
		.acc_exc  (acc_exc)
	);

	// Free running 10 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Whole run needs about a thousand cycles; twenty times that means a hang
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Bus and request tasks
	// ------------------------------------------------------------
	// One APB transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// No wait count assumed; the hang guard ends a lost answer
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Control word: state-enable present, chosen mode, gates and width
	task cf(input gicac_mode_t md, input logic m, h, x, wd);
		gicac_cfg_t c;
		c = '{xgate: x, hgate: h, mgate: m, sen: 1'b1, wide: wd, mode: md};
		apb(1'b1, `GICAC_OFS_CFG, {25'h000_0000, c});
	endtask : cf

	// Register access request, outcome checked, read data fetched
	task rq(input logic [11:0] csr, input logic wr, input logic [31:0] lo, hi,
		input gicac_exc_t ex);
		apb(1'b1, `GICAC_OFS_WLO, lo);
		apb(1'b1, `GICAC_OFS_WHI, hi);
		apb(1'b1, `GICAC_OFS_REQ, {19'h0_0000, wr, csr});
		while (acc_done !== 1'b1)
			@(posedge clock);
		`CHK("acc_exc", ex, acc_exc)
		apb(1'b0, `GICAC_OFS_RLO, 32'h0);
		rlo = rd;
		apb(1'b0, `GICAC_OFS_RHI, 32'h0);
		rhi = rd;
	endtask : rq

	// Read request shorthand
	task rr(input logic [11:0] csr, input gicac_exc_t ex);
		rq(csr, 1'b0, 32'h0, 32'h0, ex);
	endtask : rr

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values and an unmapped address
	task t_reset;
		apb(1'b0, `GICAC_OFS_CFG, 32'h0);
		`CHK("cfg", 32'h0000_007C, rd)
		apb(1'b0, `GICAC_OFS_HSL, 32'h0);
		`CHK("hsl", 32'h0000_0010, rd)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("pslverr", 1'b1, err)
		$display("test reset done");
	endtask : t_reset

	// Select range, custom bit and width changes
	task t_select;
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rq(12'h250, 1'b1, 32'h0000_0FFF, 32'h8000_0000, EXC_NONE);
		rr(12'h250, EXC_NONE);
		`CHK("sel lo", 32'h0000_0FFF, rlo)
		`CHK("sel hi", 32'h8000_0000, rhi)
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b0);
		rr(12'h250, EXC_NONE);
		`CHK("sel32 lo", 32'h8000_0FFF, rlo)
		`CHK("sel32 hi", 32'h0, rhi)
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h250, EXC_NONE);
		`CHK("sel back", 32'h8000_0000, rhi)
		rq(12'h150, 1'b1, 32'h0000_0FFF, 32'h8000_0000, EXC_NONE);
		rr(12'h150, EXC_NONE);
		`CHK("ssel", {32'h8000_0000, 32'h0000_0FFF}, {rhi, rlo})
		cf(MODE_VS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h151, EXC_ILLEGAL);
		`CHK("fault data", 32'h0, rlo)
		$display("test select done");
	endtask : t_select

	// Mode and gate decisions
	task t_gate;
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rq(12'h250, 1'b1, 32'h0000_0002, 32'h0, EXC_NONE);
		cf(MODE_VS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h250, EXC_VIRTUAL);
		rr(12'h257, EXC_VIRTUAL);
		cf(MODE_VU, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h150, EXC_VIRTUAL);
		rr(12'h153, EXC_VIRTUAL);
		cf(MODE_HS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h251, EXC_NONE);
		rr(12'h254, EXC_ILLEGAL);
		rr(12'h258, EXC_ILLEGAL);
		cf(MODE_HS, 1'b0, 1'b1, 1'b1, 1'b1);
		rr(12'h150, EXC_ILLEGAL);
		cf(MODE_VS, 1'b0, 1'b1, 1'b1, 1'b1);
		rr(12'h151, EXC_ILLEGAL);
		cf(MODE_M, 1'b0, 1'b0, 1'b0, 1'b1);
		rr(12'h251, EXC_NONE);
		cf(MODE_VS, 1'b1, 1'b0, 1'b1, 1'b1);
		rr(12'h150, EXC_VIRTUAL);
		cf(MODE_HS, 1'b1, 1'b0, 1'b1, 1'b1);
		rr(12'h150, EXC_NONE);
		cf(MODE_HS, 1'b1, 1'b1, 1'b0, 1'b1);
		rr(12'h251, EXC_ILLEGAL);
		$display("test gate done");
	endtask : t_gate

	// Redirection, alias state and select levels
	task t_alias;
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rq(12'h250, 1'b1, 32'h0000_0005, 32'h0, EXC_NONE);
		rq(12'h251, 1'b1, 32'h1234_5678, 32'h9ABC_DEF0, EXC_NONE);
		cf(MODE_VS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h151, EXC_NONE);
		`CHK("redir rd", {32'h9ABC_DEF0, 32'h1234_5678}, {rhi, rlo})
		apb(1'b0, `GICAC_OFS_RES, 32'h0);
		`CHK("res", 32'h0000_000C, rd)
		rq(12'h151, 1'b1, 32'hA5A5_0001, 32'h0, EXC_NONE);
		rq(12'h150, 1'b1, 32'h0000_0003, 32'h0, EXC_NONE);
		cf(MODE_VS, 1'b1, 1'b0, 1'b1, 1'b1);
		rq(12'h151, 1'b1, 32'h0000_DEAD, 32'h0, EXC_VIRTUAL);
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h250, EXC_NONE);
		`CHK("gsel", 32'h0000_0003, rlo)
		rq(12'h250, 1'b1, 32'h0000_0005, 32'h0, EXC_NONE);
		rr(12'h251, EXC_NONE);
		`CHK("alias kept", 32'hA5A5_0001, rlo)
		rq(12'h250, 1'b1, 32'h0000_000C, 32'h0, EXC_NONE);
		cf(MODE_VS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h151, EXC_VIRTUAL);
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		rq(12'h250, 1'b1, 32'h0000_0010, 32'h0, EXC_NONE);
		rr(12'h251, EXC_ILLEGAL);
		cf(MODE_VS, 1'b1, 1'b1, 1'b1, 1'b1);
		rr(12'h151, EXC_ILLEGAL);
		$display("test alias done");
	endtask : t_alias

	// Low clock enable holds a pending evaluation back
	task t_freeze;
		cf(MODE_M, 1'b1, 1'b1, 1'b1, 1'b1);
		apb(1'b1, `GICAC_OFS_WLO, 32'h0000_0003);
		apb(1'b1, `GICAC_OFS_WHI, 32'h0000_0000);
		apb(1'b1, `GICAC_OFS_REQ, {19'h0_0000, 1'b1, 12'h250});
		ce <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("frozen done", 1'b0, acc_done)
		ce <= 1'b1;
		while (acc_done !== 1'b1)
			@(posedge clock);
		`CHK("frozen exc", EXC_NONE, acc_exc)
		rr(12'h250, EXC_NONE);
		`CHK("frozen sel", 32'h0000_0003, rlo)
		$display("test freeze done");
	endtask : t_freeze

	// Counts, verdict and end of run
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		resetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_select();
		t_gate();
		t_alias();
		t_freeze();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
